// ===== msr_far_end.sv
// Purpose: far-end logic feeding serial data and shift clock
// Assumes: requests change at the core falling edge
// Notes:   chain mode wires all sections into one 18-stage register
`timescale 1ns/1ps
module msr_far_end (
   input  wire logic       chain_i,     // chain sections end to end
   input  wire logic       sclk_req_i,  // requested shift clock level
   input  wire logic [3:0] dat_req_i,   // serial data a..d
   input  wire logic       dly_tap_i,   // delayed tap of section a
   input  wire logic       out_b_i,     // last stage of b
   input  wire logic       out_c_i,     // last stage of c
   output logic            shift_clk_o, // shared shift clock
   output logic [3:0]      ser_o        // serial inputs a..d
);
   // ==========================================================
   // wiring
   assign shift_clk_o = sclk_req_i;
   assign ser_o[0]    = dat_req_i[0];
   // delayed tap keeps b clear of a's own shift edge
   assign ser_o[1]    = chain_i ? dly_tap_i : dat_req_i[1];
   assign ser_o[2]    = chain_i ? out_b_i : dat_req_i[2];
   assign ser_o[3]    = chain_i ? out_c_i : dat_req_i[3];
endmodule

// ===== msr_pkg.sv
// Purpose: shared constants for the multi-section shift register
// Assumes: one core clock; the shift clock arrives as a synchronous level
// Notes:   section depths and tap position are fixed
package msr_pkg;

   // ==========================================================
   // core clock
   localparam int unsigned MSR_CORE_CLK_PERIOD_NS = 50;

   // ==========================================================
   // section geometry
   localparam int unsigned MSR_NUM_SECTIONS       = 4;
   localparam int unsigned MSR_SHORT_DEPTH        = 4;
   localparam int unsigned MSR_LONG_DEPTH         = 5;
   localparam int unsigned MSR_TAP_STAGE          = 4;
   localparam int unsigned MSR_TAP_IDX            = MSR_TAP_STAGE - 1;

   // ==========================================================
   // reset values of control state
   localparam logic        MSR_SCLK_PREV_RST      = 1'b0;
   localparam logic [1:0]  MSR_RST_SYNC_RST       = 2'h0;

endpackage

// ===== msr_section.sv
// Purpose: one serial shift section of configurable depth
// Assumes: shift_i is a one-cycle strobe marking a falling shift-clock edge
// Notes:   stages carry no reset; contents are unknown until data is shifted in
`timescale 1ns/1ps
module msr_section
   import msr_pkg::*;
#(
   parameter int unsigned DEPTH = MSR_SHORT_DEPTH
) (
   input  wire logic             clk_i,    // core clock
   input  wire logic             shift_i,  // shift strobe
   input  wire logic             ser_i,    // serial data in
   output logic [DEPTH-1:0]      stage_o   // stage contents, [0] first
);

   // ==========================================================
   // stage chain
   genvar k;
   generate
      for (k = 0; k < DEPTH; k++) begin : g_stage
         wire logic stage_nxt;
         if (k == 0) begin : g_first
            assign stage_nxt = ser_i;
         end else begin : g_next
            assign stage_nxt = stage_o[k-1];
         end
         // held between strobes, so contents survive a stopped clock
         always_ff @(posedge clk_i) begin
            if (shift_i) begin
               stage_o[k] <= stage_nxt;
            end
         end
      end
   endgenerate

endmodule

// ===== msr_top.sv
// Purpose: four independent static shift sections sharing one shift clock
// Assumes: shift_clk_i and serial inputs are synchronous to core_clk_i
// Notes:   a shift happens in the core cycle that first sees shift_clk_i low
//
// Operation
// - four sections: two of four stages and two of five stages.
// - each five-stage section also outputs its fourth stage.
// - every section has its own serial input; no internal data between sections.
// - one shared clock; each falling edge while out of reset moves every stage one place on.
// - extra output copies the fourth-stage tap half a cycle later, else holds.
// - contents hold indefinitely while the clock rests at either level.
`timescale 1ns/1ps
module msr_top
   import msr_pkg::*;
(
   input  wire logic core_clk_i,                  // core clock, 20 MHz
   input  wire logic rstn_i,                      // async reset, active low
   input  wire logic shift_clk_i,                 // shared shift clock level
   input  wire logic ser_a_i,                     // serial in, four-stage section a
   input  wire logic ser_b_i,                     // serial in, four-stage section b
   input  wire logic ser_c_i,                     // serial in, five-stage section c
   input  wire logic ser_d_i,                     // serial in, five-stage section d
   output logic      fourth_stage_tap_o,          // last stage of section a
   output logic      half_cycle_delayed_tap_o,    // tap a, half cycle later
   output logic      out_b_o,                     // last stage of section b
   output logic      tap_c_o,                     // fourth stage of section c
   output logic      out_c_o,                     // last stage of section c
   output logic      tap_d_o,                     // fourth stage of section d
   output logic      out_d_o                      // last stage of section d
);

   // ==========================================================
   // reset release
   logic [1:0] rst_sync_r;
   wire  logic rst_n;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= MSR_RST_SYNC_RST;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // ==========================================================
   // shift-clock edge detection
   logic       sclk_prev_r;
   wire  logic sclk_fall;
   wire  logic sclk_rise;

   // prev resets low so a clock resting low after reset gives no false fall
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_r <= MSR_SCLK_PREV_RST;
      end else begin
         sclk_prev_r <= shift_clk_i;
      end
   end

   assign sclk_fall = rst_n &  sclk_prev_r & ~shift_clk_i;
   assign sclk_rise = rst_n & ~sclk_prev_r &  shift_clk_i;

   // ==========================================================
   // sections
   wire logic [MSR_SHORT_DEPTH-1:0] stg_a;
   wire logic [MSR_SHORT_DEPTH-1:0] stg_b;
   wire logic [MSR_LONG_DEPTH-1:0]  stg_c;
   wire logic [MSR_LONG_DEPTH-1:0]  stg_d;

   msr_section #(.DEPTH(MSR_SHORT_DEPTH)) u_sec_a (
      .clk_i   (core_clk_i),
      .shift_i (sclk_fall),
      .ser_i   (ser_a_i),
      .stage_o (stg_a)
   );

   msr_section #(.DEPTH(MSR_SHORT_DEPTH)) u_sec_b (
      .clk_i   (core_clk_i),
      .shift_i (sclk_fall),
      .ser_i   (ser_b_i),
      .stage_o (stg_b)
   );

   msr_section #(.DEPTH(MSR_LONG_DEPTH)) u_sec_c (
      .clk_i   (core_clk_i),
      .shift_i (sclk_fall),
      .ser_i   (ser_c_i),
      .stage_o (stg_c)
   );

   msr_section #(.DEPTH(MSR_LONG_DEPTH)) u_sec_d (
      .clk_i   (core_clk_i),
      .shift_i (sclk_fall),
      .ser_i   (ser_d_i),
      .stage_o (stg_d)
   );

   // ==========================================================
   // outputs, all straight from stage flops
   assign fourth_stage_tap_o = stg_a[MSR_SHORT_DEPTH-1];
   assign out_b_o            = stg_b[MSR_SHORT_DEPTH-1];
   assign tap_c_o            = stg_c[MSR_TAP_IDX];
   assign out_c_o            = stg_c[MSR_LONG_DEPTH-1];
   assign tap_d_o            = stg_d[MSR_TAP_IDX];
   assign out_d_o            = stg_d[MSR_LONG_DEPTH-1];

   // ==========================================================
   // half-cycle delayed tap
   // follows the tap on the rising edge, so it is stable across the fall
   // that a downstream stage samples; no reset, like the stages
   logic half_tap_r;

   always_ff @(posedge core_clk_i) begin
      if (sclk_rise) begin
         half_tap_r <= fourth_stage_tap_o;
      end
   end

   assign half_cycle_delayed_tap_o = half_tap_r;

   // ==========================================================
   // checks
   // stages power up unknown, so exact equality keeps an unknown pair from firing
   property p_first_stage_loads;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (stg_a[0] === $past(ser_a_i));
   endproperty
   a_first_stage_loads: assert property (p_first_stage_loads)
      else $error("first stage did not take serial input on falling edge");

   property p_chain_moves;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (stg_c[MSR_LONG_DEPTH-1:1] === $past(stg_c[MSR_LONG_DEPTH-2:0]));
   endproperty
   a_chain_moves: assert property (p_chain_moves)
      else $error("five-stage chain did not shift by one place");

   property p_hold_between_edges;
      @(posedge core_clk_i) disable iff (!rst_n)
      (!sclk_fall && !$past(sclk_fall)) |=> ((stg_b === $past(stg_b)) && (stg_d === $past(stg_d)));
   endproperty
   a_hold_between_edges: assert property (p_hold_between_edges)
      else $error("stage contents changed without a falling edge");

   property p_tap_tracks;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (tap_d_o === $past(stg_d[MSR_TAP_IDX-1])) ##0 (out_d_o === $past(tap_d_o));
   endproperty
   a_tap_tracks: assert property (p_tap_tracks)
      else $error("fourth-stage tap out of step with its chain");

   property p_sections_independent;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (stg_b[0] === $past(ser_b_i)) && (stg_d[0] === $past(ser_d_i));
   endproperty
   a_sections_independent: assert property (p_sections_independent)
      else $error("section first stage not fed from its own input");

   property p_half_follows;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_rise |=> (half_cycle_delayed_tap_o === $past(fourth_stage_tap_o));
   endproperty
   a_half_follows: assert property (p_half_follows)
      else $error("delayed tap did not follow tap on rising edge");

   property p_half_holds;
      @(posedge core_clk_i) disable iff (!rst_n)
      (!sclk_rise && $past(rst_n)) |=> (half_cycle_delayed_tap_o === $past(half_cycle_delayed_tap_o));
   endproperty
   a_half_holds: assert property (p_half_holds)
      else $error("delayed tap changed outside rising edge");

   property p_half_lags_fall;
      @(posedge core_clk_i) disable iff (!rst_n)
      (sclk_fall ##1 !sclk_rise) |-> (half_cycle_delayed_tap_o === $past(half_cycle_delayed_tap_o));
   endproperty
   a_half_lags_fall: assert property (p_half_lags_fall)
      else $error("delayed tap moved together with the falling edge");

   property p_fall_rise_exclusive;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |-> !sclk_rise ##1 !sclk_fall;
   endproperty
   a_fall_rise_exclusive: assert property (p_fall_rise_exclusive)
      else $error("edge detector gave overlapping or repeated strobes");

   property p_short_chain_moves;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (stg_b[MSR_SHORT_DEPTH-1:1] === $past(stg_b[MSR_SHORT_DEPTH-2:0]));
   endproperty
   a_short_chain_moves: assert property (p_short_chain_moves)
      else $error("four-stage chain did not shift by one place");

   property p_tap_c_tracks;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (tap_c_o === $past(stg_c[MSR_TAP_IDX-1])) && (out_c_o === $past(tap_c_o));
   endproperty
   a_tap_c_tracks: assert property (p_tap_c_tracks)
      else $error("tap of section c out of step with its chain");

   property p_last_outputs;
      @(posedge core_clk_i) disable iff (!rst_n)
      sclk_fall |=> (fourth_stage_tap_o === $past(stg_a[MSR_SHORT_DEPTH-2]))
                    && (out_b_o === $past(stg_b[MSR_SHORT_DEPTH-2]));
   endproperty
   a_last_outputs: assert property (p_last_outputs)
      else $error("four-stage section output not fed from its third stage");

   // no disable here: stages must keep their contents while reset is held
   property p_reset_keeps_stages;
      @(posedge core_clk_i)
      !rst_n |=> (stg_a === $past(stg_a)) && (stg_c === $past(stg_c)) && (half_tap_r === $past(half_tap_r));
   endproperty
   a_reset_keeps_stages: assert property (p_reset_keeps_stages)
      else $error("stage contents moved while reset was held");

endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for the multi-section shift register
// Assumes: inputs change at the core falling edge
// Notes:   reference stages start unknown; unknown expectations skipped
`timescale 1ns/1ps
module tb_top;
   import msr_pkg::*;
   logic       core_clk = 1'b0;
   logic       rstn     = 1'b0;
   logic       chain    = 1'b0;
   logic       sclk     = 1'b0;
   logic [3:0] dat      = 4'h0;
   logic       sclk_w;
   logic [3:0] ser;
   logic       tap_a, dly, ob, tc, oc, td, od;
   logic [3:0] ra = 4'hx, rb = 4'hx, s_exp;
   logic [4:0] rc = 5'hx, rd = 5'hx;
   logic       rdly = 1'bx, rprev = 1'b0;
   int         errors = 0;
   int         n_tests = 0;
   int         cyc = 0;

   always #25 core_clk = ~core_clk;

   msr_top i_dut (.core_clk_i(core_clk), .rstn_i(rstn), .shift_clk_i(sclk_w),
      .ser_a_i(ser[0]), .ser_b_i(ser[1]), .ser_c_i(ser[2]), .ser_d_i(ser[3]),
      .fourth_stage_tap_o(tap_a), .half_cycle_delayed_tap_o(dly), .out_b_o(ob),
      .tap_c_o(tc), .out_c_o(oc), .tap_d_o(td), .out_d_o(od));
   msr_far_end i_far (.chain_i(chain), .sclk_req_i(sclk), .dat_req_i(dat),
      .dly_tap_i(dly), .out_b_i(ob), .out_c_i(oc), .shift_clk_o(sclk_w), .ser_o(ser));

   // ==========================================================
   // reference model, chained inputs taken from the model itself
   function automatic logic [3:0] exp_ser();
      return chain ? {rc[4], rb[3], rdly, dat[0]} : dat;
   endfunction

   always @(posedge core_clk) begin
      s_exp = exp_ser();
      if (rprev && !sclk_w) begin
         ra = {ra[2:0], s_exp[0]};
         rb = {rb[2:0], s_exp[1]};
         rc = {rc[3:0], s_exp[2]};
         rd = {rd[3:0], s_exp[3]};
      end
      if (!rprev && sclk_w) rdly = ra[3];
      rprev = sclk_w;
      cyc++;
      if (cyc > 10000) begin
         errors++;
         finish_test();
      end
   end

   // ==========================================================
   // checks and stimulus
   task automatic chk(logic got, logic exp, string what);
      n_tests++;
      if (!$isunknown(exp) && got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   task automatic drive(logic sc, logic [3:0] d);
      @(negedge core_clk);
      chk(tap_a, ra[3], "tap a");
      chk(dly, rdly, "delayed tap");
      chk(ob, rb[3], "out b");
      chk(tc, rc[3], "tap c");
      chk(oc, rc[4], "out c");
      chk(td, rd[3], "tap d");
      chk(od, rd[4], "out d");
      sclk = sc;
      dat  = d;
   endtask

   // hold lengths of one give back-to-back toggling
   task automatic burst(int n, int maxhold);
      logic sc;
      sc = sclk;
      repeat (n) begin
         sc = ~sc;
         repeat ($urandom_range(maxhold, 1)) drive(sc, 4'($urandom));
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      void'($urandom(23));
      repeat (8) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) drive(1'b0, 4'h0);
      burst(300, 6);
      burst(4, 60);
      repeat (2) drive(1'b0, 4'($urandom));
      rstn = 1'b0;
      repeat (3) drive(1'b0, 4'($urandom));
      rstn = 1'b1;
      repeat (4) drive(1'b0, 4'($urandom));
      chain = 1'b1;
      burst(300, 4);
      repeat (2) drive(1'b0, 4'h0);
      finish_test();
   end
endmodule
